// file: core/dioc_pkg.sv
// dioc_pkg: register map, field positions and reset values of the digital i/o block
// assumes a byte-addressed plain register port with 32-bit data
package dioc_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          LINES         = 8;
  localparam int          CNT_W         = 16;
  localparam int          SEL_W         = 3;
  localparam int unsigned SYS_CLK_HZ    = 40_000_000;

  // register byte offsets
  localparam logic [7:0]  OFS_OUT_CMD   = 8'h00;
  localparam logic [7:0]  OFS_IN_LEVELS = 8'h04;
  localparam logic [7:0]  OFS_COUNT     = 8'h08;
  localparam logic [7:0]  OFS_CTRL      = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;

  // out_cmd fields: line select and level value
  localparam int          OUT_SEL_LSB   = 0;
  localparam int          OUT_LEVEL_BIT = 8;
  // count register: overload flag above the count
  localparam int          CNT_OVL_BIT   = 16;
  // ctrl: zero request
  localparam int          CTRL_ZERO_BIT = 0;

  // interrupt status layout
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_COUNT_BIT = 0;
  localparam int          IRQ_OVL_BIT   = 1;
  localparam int          IRQ_IN_BIT    = 2;

  // reset values
  localparam logic [7:0]  OUT_RST       = 8'hFF;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [15:0] CNT_FULL      = 16'hFFFF;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;
endpackage : dioc_pkg

// file: core/dioc_sync.sv
// dioc_sync: two-flop synchroniser for a bus of asynchronous pin levels
// assumes each bit is an independent level; no bus coherency across bits
`timescale 1ns/10ps
`default_nettype none
module dioc_sync #(
  parameter int             W      = 1,
  parameter logic [W-1:0]   RST_V  = '0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // meta_r is read only by the second stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= RST_V;
      sync_out <= RST_V;
    end else begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule : dioc_sync
`default_nettype wire

// file: core/dioc_totalizer.sv
// dioc_totalizer: 16-bit saturating event counter with preset, zero and overload
// assumes inc is a one-cycle pulse already synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module dioc_totalizer
  import dioc_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // control
  input  wire logic             inc,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  input  wire logic             zero,
  // state
  output var  logic [CNT_W-1:0] count_r,
  output var  logic             overload_indication,
  output logic                  step_evt,
  output logic                  ovl_evt
);
  logic [CNT_W-1:0] count_nxt;
  logic             ovl_nxt;
  wire              at_full = (count_r == CNT_FULL);
  wire              host_op = load | zero;

  // host action beats a same-cycle input edge: the host value is what it asked for
  assign step_evt = inc & ~host_op & ~overload_indication & ~at_full;
  assign ovl_evt  = inc & ~host_op & ~overload_indication & at_full;

  always_comb begin
    count_nxt = count_r;
    ovl_nxt   = overload_indication;
    if (zero) begin
      count_nxt = CNT_RST;
      ovl_nxt   = 1'b0;
    end else if (load) begin
      count_nxt = load_val;
      ovl_nxt   = 1'b0;
    end else if (step_evt) begin
      count_nxt = count_r + 16'h0001;
    end else if (ovl_evt) begin
      ovl_nxt   = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r             <= CNT_RST;
      overload_indication <= 1'b0;
    end else begin
      count_r             <= count_nxt;
      overload_indication <= ovl_nxt;
    end
  end
endmodule : dioc_totalizer
`default_nettype wire

// file: core/dioc_top.sv
// dioc_top: eight output lines, eight input lines and an event counter behind a register port
// assumes pins are asynchronous, inputs have external pull-ups, one 40 MHz clock
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dioc_top
  import dioc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  // digital pins
  output var  logic [LINES-1:0]  dout,
  input  wire logic [LINES-1:0]  din,
  input  wire logic              count_in,
  // status
  output var  logic              overload_indication,
  output logic                   irq
);
  // ---------------------------------------------------------------- decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire wr_out   = reg_wr & hit(reg_addr, OFS_OUT_CMD);
  wire wr_count = reg_wr & hit(reg_addr, OFS_COUNT);
  wire wr_ctrl  = reg_wr & hit(reg_addr, OFS_CTRL);
  wire wr_stat  = reg_wr & hit(reg_addr, OFS_IRQ_STAT);
  wire wr_mask  = reg_wr & hit(reg_addr, OFS_IRQ_MASK);

  // ---------------------------------------------------------------- outputs
  wire [SEL_W-1:0] out_sel   = reg_wdata[OUT_SEL_LSB +: SEL_W];
  wire             out_level = reg_wdata[OUT_LEVEL_BIT];
  wire [LINES-1:0] sel_mask  = 8'h01 << out_sel;
  logic [LINES-1:0] dout_nxt;

  // active-low lines: level 0 means on, 1 means off
  assign dout_nxt = out_level ? (dout | sel_mask)
                              : (dout & ~sel_mask);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout <= OUT_RST;
    end else if (wr_out) begin
      dout <= dout_nxt;
    end
  end

  // ---------------------------------------------------------------- inputs
  logic [LINES-1:0] din_s;
  logic             cnt_s;
  logic             cnt_prev_r;
  logic [LINES-1:0] din_prev_r;

  // reset to ones, the open-input level, so no false change after reset
  dioc_sync #(.W(LINES), .RST_V(8'hFF)) u_din_sync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pin_in   (din),
    .sync_out (din_s)
  );

  dioc_sync #(.W(1), .RST_V(1'b1)) u_cnt_sync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pin_in   (count_in),
    .sync_out (cnt_s)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_prev_r <= 1'b1;
      din_prev_r <= 8'hFF;
    end else begin
      cnt_prev_r <= cnt_s;
      din_prev_r <= din_s;
    end
  end

  // a rising edge closes one low-then-high cycle; input must stay
  // low and high two clocks each, far above any usable count rate
  wire cnt_rise  = cnt_s & ~cnt_prev_r;
  wire in_change = |(din_s ^ din_prev_r);

  // ---------------------------------------------------------------- counter
  logic [CNT_W-1:0] count_r;
  logic             step_evt;
  logic             ovl_evt;
  wire              zero_req = wr_ctrl & reg_wdata[CTRL_ZERO_BIT];

  dioc_totalizer u_total (
    .sys_clk             (sys_clk),
    .arst_n              (arst_n),
    .inc                 (cnt_rise),
    .load                (wr_count),
    .load_val            (reg_wdata[CNT_W-1:0]),
    .zero                (zero_req),
    .count_r             (count_r),
    .overload_indication (overload_indication),
    .step_evt            (step_evt),
    .ovl_evt             (ovl_evt)
  );

  // ---------------------------------------------------------------- interrupts
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_stat_nxt;

  assign irq_set      = {in_change, ovl_evt, step_evt};
  // set beats a same-cycle write-one clear
  assign irq_stat_nxt = (irq_stat_r & ~({IRQ_W{wr_stat}} & reg_wdata[IRQ_W-1:0]))
                      | irq_set;
  assign irq          = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_r <= '0;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_mask) begin
        irq_mask_r <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------- read path
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      OFS_OUT_CMD:   rd_mux[LINES-1:0] = dout;
      OFS_IN_LEVELS: rd_mux[LINES-1:0] = din_s;
      OFS_COUNT:     rd_mux = {15'h0000, overload_indication, count_r};
      OFS_IRQ_STAT:  rd_mux[IRQ_W-1:0] = irq_stat_r;
      OFS_IRQ_MASK:  rd_mux[IRQ_W-1:0] = irq_mask_r;
      default:       rd_mux = '0;
    endcase
  end

  // read data stands for one cycle only, zero otherwise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------- assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic any_out_wr_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      any_out_wr_r <= 1'b0;
    end else if (wr_out) begin
      any_out_wr_r <= 1'b1;
    end
  end

  wire no_host = ~wr_count & ~zero_req;

  a_out_idle_off: assert property (
    !any_out_wr_r |-> dout == 8'hFF)
    else $error("outputs not all off before first command");

  a_out_drive_low: assert property (
    wr_out && !out_level |=> dout[$past(out_sel)] == 1'b0)
    else $error("selected line not driven low");

  a_out_drive_high: assert property (
    wr_out && out_level |=> dout[$past(out_sel)] == 1'b1)
    else $error("selected line not returned high");

  a_out_others_keep: assert property (
    wr_out |=> ((dout ^ $past(dout)) & ~$past(sel_mask)) == 8'h00)
    else $error("unselected line changed");

  a_in_read_word: assert property (
    reg_rd && reg_addr == OFS_IN_LEVELS |=> reg_rdata == {24'h00_0000, $past(din_s)})
    else $error("input query word wrong");

  a_in_open_ones: assert property (
    (din == 8'hFF) [*3] |=> din_s == 8'hFF)
    else $error("open inputs not read as ones");

  a_in_ground_zero: assert property (
    (din == 8'hFE) [*3] |=> din_s == 8'hFE)
    else $error("grounded input 0 not read as zero");

  a_cnt_step_one: assert property (
    cnt_rise && no_host && !overload_indication && count_r != 16'hFFFF
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("count did not step by one");

  a_cnt_edge_only: assert property (
    !cnt_rise && no_host |=> $stable(count_r))
    else $error("count moved without an input cycle");

  a_cnt_preset: assert property (
    wr_count && !zero_req |=> count_r == $past(reg_wdata[15:0]) && !overload_indication)
    else $error("preset not loaded");

  a_cnt_saturate: assert property (
    cnt_rise && no_host && count_r == 16'hFFFF
    |=> count_r == 16'hFFFF && overload_indication && irq_stat_r[1])
    else $error("full count wrapped or no overload");

  a_cnt_zero: assert property (
    zero_req |=> count_r == 16'h0000 && !overload_indication
    ##1 (count_r <= 16'h0001 || $past(wr_count)))
    else $error("zero request did not clear count");

  a_ovl_hold: assert property (
    overload_indication && no_host |=> overload_indication && $stable(count_r))
    else $error("overload not held");

  a_sync_depth: assert property (
    $rose(count_in) |=> !cnt_s ##1 cnt_s)
    else $error("count pin not through two stages");

  a_in_settle: assert property (
    $changed(din) |=> din_s != $past(din) ##1 din_s == $past(din, 2))
    else $error("input pins not through two stages");

  a_irq_follow: assert property (
    (irq_stat_r & irq_mask_r) != 3'h0 |-> irq ##1 (irq || $past(wr_stat) || $past(wr_mask)))
    else $error("interrupt not raised for unmasked status");

  a_irq_set_wins: assert property (
    irq_set != 3'h0 |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
    else $error("status event lost");

  a_irq_w1c: assert property (
    wr_stat && irq_set == 3'h0 |=> (irq_stat_r & $past(reg_wdata[IRQ_W-1:0])) == 3'h0)
    else $error("write-one did not clear status");

  a_mask_write: assert property (
    wr_mask |=> irq_mask_r == $past(reg_wdata[IRQ_W-1:0]))
    else $error("mask write not taken");

  a_rd_idle_zero: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read");

  a_rd_count_word: assert property (
    reg_rd && reg_addr == OFS_COUNT
    |=> reg_rdata == {15'h0000, $past(overload_indication), $past(count_r)})
    else $error("count read word wrong");

  a_out_read_back: assert property (
    reg_rd && reg_addr == OFS_OUT_CMD |=> reg_rdata == {24'h00_0000, $past(dout)})
    else $error("output read back wrong");

  a_rd_ctrl_zero: assert property (
    reg_rd && reg_addr == OFS_CTRL |=> reg_rdata == 32'h0000_0000)
    else $error("control read not zero");

  a_ovl_count_full: assert property (
    overload_indication |-> count_r == 16'hFFFF)
    else $error("overload without full count");

  a_cnt_no_wrap: assert property (
    count_r == 16'hFFFF && no_host |=> count_r == 16'hFFFF)
    else $error("full count wrapped");

  c_overload: cover property (
    count_r == 16'hFFFF ##[1:20] overload_indication);

  c_preset_step: cover property (
    wr_count ##[1:20] step_evt);

  c_in_grounded: cover property (
    reg_rd && reg_addr == OFS_IN_LEVELS && din_s != 8'hFF);

  c_line_on_off: cover property (
    wr_out && !out_level ##[1:20] wr_out && out_level);

endmodule : dioc_top
`default_nettype wire

// file: verification/dioc_pins.sv
// dioc_pins: pin-side fixture, pull-ups on inputs, jumper and pulse source
// assumes the bench changes its controls just after rising clock edges
`timescale 1ns/10ps
`default_nettype none
module dioc_pins (
  // clock
  input  wire logic       sys_clk,
  // fixture controls
  input  wire logic [7:0] gnd_mask,
  input  wire logic       jumper,
  input  wire logic       gen_en,
  // device pins
  input  wire logic       dout0,
  output logic [7:0]      din,
  output logic            count_in
);
  logic [2:0] ph_r;
  logic       gen_sig;
  // open lines float up to 1, grounded lines read 0
  assign din      = ~gnd_mask;
  // period 8 clocks, low half first, so each period is one whole cycle
  assign gen_sig  = gen_en & ph_r[2];
  assign count_in = jumper ? dout0 : gen_sig;
  always_ff @(posedge sys_clk) begin
    ph_r <= gen_en ? ph_r + 3'h1 : 3'h0;
  end
endmodule : dioc_pins
`default_nettype wire

// file: verification/dioc_top_tb.sv
// dioc_top_tb: self-checking bench for outputs, inputs, counter, interrupts
// assumes a 40 MHz clock and the register map of dioc_pkg
`timescale 1ns/10ps
`default_nettype none
module dioc_top_tb
  import dioc_pkg::*;
;
  logic              sys_clk;
  logic              arst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [LINES-1:0]  dout;
  logic [LINES-1:0]  din;
  logic              count_in;
  logic              overload_indication;
  logic              irq;
  logic [7:0]        gnd_mask;
  logic              jumper;
  logic              gen_en;
  logic [DATA_W-1:0] rv;
  int                n_errors;
  int                num_checks;
  int                cyc = 0;

  dioc_top dioc_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dout(dout), .din(din), .count_in(count_in),
    .overload_indication(overload_indication), .irq(irq));
  dioc_pins dioc_pins_inst (.sys_clk(sys_clk), .gnd_mask(gnd_mask), .jumper(jumper),
    .gen_en(gen_en), .dout0(dout[0]), .din(din), .count_in(count_in));

  always #12.5 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // hang guard, the whole run needs under 2000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end

  function automatic logic [31:0] oc(input int ln, input logic lv);
    oc = 32'(ln) | (32'(lv) << OUT_LEVEL_BIT);
  endfunction : oc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    rv = reg_rdata;
    num_checks++;
    if (rv !== e) begin
      n_errors++;
      $display("FAIL %0t reg %h read %h want %h", $time, a, rv, e);
    end
  endtask : chk_reg

  // callers sample pins at a falling edge, after updates have landed
  task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t pin %h want %h", $time, g, e);
    end
  endtask : chk_pin

  task automatic pulse();
    wr(OFS_OUT_CMD, oc(0, 1'b0));
    repeat (4) @(posedge sys_clk);
    wr(OFS_OUT_CMD, oc(0, 1'b1));
    repeat (6) @(posedge sys_clk);
  endtask : pulse

  task automatic t_reset();
    @(negedge sys_clk);
    chk_pin(dout, OUT_RST);
    chk_pin({7'h00, irq | overload_indication}, 8'h00);
    chk_reg(OFS_COUNT, 32'h0000_0000);
    chk_reg(OFS_IRQ_MASK, 32'h0000_0000);
  endtask : t_reset

  task automatic t_outputs();
    logic [7:0] e;
    e = 8'hFF;
    for (int n = 0; n < 2 * LINES; n++) begin
      wr(OFS_OUT_CMD, oc(n % LINES, n >= LINES));
      e[n % LINES] = (n >= LINES);
      @(negedge sys_clk);
      chk_pin(dout, e);
      if (n == LINES - 1) chk_reg(OFS_OUT_CMD, 32'h0000_0000);
    end
  endtask : t_outputs

  task automatic t_inputs();
    for (int n = -1; n < LINES; n++) begin
      @(posedge sys_clk);
      gnd_mask <= (n < 0) ? 8'h00 : 8'h01 << n;
      repeat (4) @(posedge sys_clk);
      chk_reg(OFS_IN_LEVELS, (n < 0) ? 32'h0000_00FF : 32'h0000_00FF - (32'h1 << n));
    end
    @(posedge sys_clk);
    gnd_mask <= 8'h00;
  endtask : t_inputs

  task automatic t_count();
    @(posedge sys_clk);
    jumper <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wr(OFS_CTRL, 32'h0000_0001);
    chk_reg(OFS_COUNT, 32'h0000_0000);
    pulse();
    chk_reg(OFS_COUNT, 32'h0000_0001);
    pulse();
    chk_reg(OFS_COUNT, 32'h0000_0002);
  endtask : t_count

  task automatic t_overload();
    wr(OFS_COUNT, 32'h0000_FFFE);
    pulse();
    chk_reg(OFS_COUNT, 32'h0000_FFFF);
    pulse();
    chk_reg(OFS_COUNT, 32'h0001_FFFF);
    chk_reg(OFS_IRQ_STAT, 32'h0000_0007);
    pulse();
    chk_reg(OFS_COUNT, 32'h0001_FFFF);
    chk_pin({7'h00, overload_indication}, 8'h01);
    wr(OFS_CTRL, 32'h0000_0001);
    chk_reg(OFS_COUNT, 32'h0000_0000);
  endtask : t_overload

  task automatic t_irq();
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    chk_reg(OFS_IRQ_STAT, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    pulse();
    chk_reg(OFS_IRQ_STAT, 32'h0000_0001);
    chk_pin({7'h00, irq}, 8'h01);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    @(negedge sys_clk);
    chk_pin({7'h00, irq}, 8'h00);
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    chk_reg(OFS_IRQ_STAT, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    chk_reg(8'h20, 32'h0000_0000);
  endtask : t_irq

  // ten whole periods of 8 clocks must give ten counts
  task automatic t_rate();
    @(posedge sys_clk);
    jumper <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0001);
    @(posedge sys_clk);
    gen_en <= 1'b1;
    repeat (80) @(posedge sys_clk);
    gen_en <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_reg(OFS_COUNT, 32'h0000_000A);
  endtask : t_rate

  initial begin
    sys_clk    = 1'b0;
    arst_n     = 1'b0;
    reg_addr   = '0;
    reg_wdata  = '0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    gnd_mask   = 8'h00;
    jumper     = 1'b0;
    gen_en     = 1'b0;
    n_errors   = 0;
    num_checks = 0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_outputs();
    t_inputs();
    t_count();
    t_overload();
    t_irq();
    t_rate();
    report_and_stop();
  end
endmodule : dioc_top_tb
`default_nettype wire
